/* File: nim_irq_mask.sv */
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module nim_irq_mask (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [7:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output      logic [31:0]           dat_o,
  output      logic                  ack_o,
  // Event pulses from the controller
  input  wire nim_pkg::nim_events_s  events_i,
  // Interrupt
  output      logic                  irq_o
);

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic word_hit(input logic [7:0] adr,
                                    input logic [7:0] ofs);
    word_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [15:0] lanes(input logic [3:0] sel);
    lanes = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ********************************************************************
  // Bus decode
  // ********************************************************************
  logic        req;
  logic        wr;
  logic        rd;
  logic        hit_status;
  logic        hit_mask;
  logic [15:0] wlanes;
  logic [15:0] evt_v;
  logic [15:0] clr_v;
  logic [15:0] status;
  logic [15:0] mask;
  logic [31:0] next_rdata;

  // Ack drops by itself, so a held strobe takes a new access every second clock
  assign req        = cyc_i & stb_i & ~ack_o;
  assign wr         = req & we_i;
  assign rd         = req & ~we_i;
  assign hit_status = word_hit(adr_i, nim_pkg::STATUS_OFS);
  assign hit_mask   = word_hit(adr_i, nim_pkg::MASK_OFS);
  assign wlanes     = lanes(sel_i);
  assign evt_v      = events_i & nim_pkg::IMPL_BITS;
  assign clr_v      = (wr && hit_status) ? (dat_i[15:0] & wlanes) : 16'h0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // ********************************************************************
  // Enable mask
  // ********************************************************************
  // Reserved bits are not stored, so a stray one cannot raise the line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= nim_pkg::MASK_RESET;
    end else if (wr && hit_mask) begin
      mask <= (mask & ~wlanes) | (dat_i[15:0] & wlanes & nim_pkg::IMPL_BITS);
    end
  end

  // ********************************************************************
  // Sticky status
  // ********************************************************************
  // Set wins over a write-one clear in the same cycle; mask not consulted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= nim_pkg::STATUS_RESET;
    end else begin
      status <= (status & ~clr_v) | evt_v;
    end
  end

  // ********************************************************************
  // Interrupt output
  // ********************************************************************
  // Registered, so it trails the status by one clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

  // ********************************************************************
  // Read data
  // ********************************************************************
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_status) begin
      next_rdata = {16'h0000, status};
    end else if (hit_mask) begin
      next_rdata = {16'h0000, mask};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd) begin
      dat_o <= next_rdata;
    end else begin
      dat_o <= 32'h0000_0000;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  sequence ev_armed(int b);
    (evt_v[b] && mask[b]) ##1 mask[b];
  endsequence

  property ev_irq_p(int b);
    @(posedge clk_i) disable iff (rst_i)
      ev_armed(b) |=> irq_o;
  endproperty

  // Masked events are still recorded; only the line must stay low
  sequence ev_masked(int b);
    (evt_v[b] && !mask[b]) ##1 ((status & mask) == 16'h0000);
  endsequence

  property ev_quiet_p(int b);
    @(posedge clk_i) disable iff (rst_i)
      ev_masked(b) |=> !irq_o;
  endproperty

  bus_retry_irq_a: assert property (ev_irq_p(nim_pkg::BUS_RETRY_BIT))
    else $error("bus retry event did not interrupt");

  hb_lost_irq_a: assert property (ev_irq_p(nim_pkg::HB_LOST_BIT))
    else $error("heartbeat lost event did not interrupt");

  filter_load_irq_a: assert property (ev_irq_p(nim_pkg::FILTER_LOAD_BIT))
    else $error("filter load done did not interrupt");

  per_packet_irq_a: assert property (ev_irq_p(nim_pkg::PER_PACKET_BIT))
    else $error("descriptor request did not interrupt");

  rx_packet_irq_a: assert property (ev_irq_p(nim_pkg::RX_PACKET_BIT))
    else $error("received packet did not interrupt");

  tx_done_irq_a: assert property (ev_irq_p(nim_pkg::TX_DONE_BIT))
    else $error("transmit done did not interrupt");

  tx_error_irq_a: assert property (ev_irq_p(nim_pkg::TX_ERROR_BIT))
    else $error("transmit error did not interrupt");

  align_tally_irq_a: assert property (ev_irq_p(nim_pkg::ALIGN_TALLY_BIT))
    else $error("alignment tally warning did not interrupt");

  missed_tally_irq_a: assert property (ev_irq_p(nim_pkg::MISSED_PKT_BIT))
    else $error("missed packet warning did not interrupt");

  overrun_irq_a: assert property (ev_irq_p(nim_pkg::RX_OVERRUN_BIT))
    else $error("receive overrun did not interrupt");

  crc_tally_irq_a: assert property (ev_irq_p(nim_pkg::CRC_TALLY_BIT))
    else $error("crc tally warning did not interrupt");

  retry_masked_a: assert property (ev_quiet_p(nim_pkg::BUS_RETRY_BIT))
    else $error("masked bus retry raised the interrupt");

  hb_masked_a: assert property (ev_quiet_p(nim_pkg::HB_LOST_BIT))
    else $error("masked heartbeat lost raised the interrupt");

  filter_masked_a: assert property (ev_quiet_p(nim_pkg::FILTER_LOAD_BIT))
    else $error("masked filter load done raised the interrupt");

  per_packet_masked_a: assert property (ev_quiet_p(nim_pkg::PER_PACKET_BIT))
    else $error("masked descriptor request raised the interrupt");

  rx_masked_a: assert property (ev_quiet_p(nim_pkg::RX_PACKET_BIT))
    else $error("masked received packet raised the interrupt");

  tx_done_masked_a: assert property (ev_quiet_p(nim_pkg::TX_DONE_BIT))
    else $error("masked transmit done raised the interrupt");

  tx_err_masked_a: assert property (ev_quiet_p(nim_pkg::TX_ERROR_BIT))
    else $error("masked transmit error raised the interrupt");

  align_masked_a: assert property (ev_quiet_p(nim_pkg::ALIGN_TALLY_BIT))
    else $error("masked alignment warning raised the interrupt");

  missed_masked_a: assert property (ev_quiet_p(nim_pkg::MISSED_PKT_BIT))
    else $error("masked missed packet warning raised the interrupt");

  overrun_masked_a: assert property (ev_quiet_p(nim_pkg::RX_OVERRUN_BIT))
    else $error("masked receive overrun raised the interrupt");

  crc_masked_a: assert property (ev_quiet_p(nim_pkg::CRC_TALLY_BIT))
    else $error("masked crc tally warning raised the interrupt");

  irq_cause_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      irq_o |-> (($past(status) & $past(mask)) != 16'h0000))
    else $error("interrupt without an enabled flag");

  irq_fall_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ((status & mask) == 16'h0000) |=> !irq_o)
    else $error("interrupt stayed up with no enabled flag");

  flag_record_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (evt_v != 16'h0000) |=> ((status & $past(evt_v)) == $past(evt_v)))
    else $error("event not recorded in status");

  // Status moves only on an event or a write-one clear
  clear_w1c_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (clr_v != 16'h0000) |=> ((status & $past(clr_v) & ~$past(evt_v)) == 16'h0000))
    else $error("write-one clear did not clear");

  status_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ((evt_v == 16'h0000) && (clr_v == 16'h0000)) |=> $stable(status))
    else $error("status changed with no cause");

  mask_readback_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (rd && hit_mask) |=> (dat_o == {16'h0000, $past(mask)}))
    else $error("mask read back wrong");

  mask_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      !(wr && hit_mask) |=> $stable(mask))
    else $error("mask changed without a write");

  reserved_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ((mask | status) & ~nim_pkg::IMPL_BITS) == 16'h0000)
    else $error("reserved bit became set");

  // ********************************************************************
  // Bus checks
  // ********************************************************************
  // Read data stands only in the ack cycle and is zero otherwise
  sequence ack_pulse;
    ack_o ##1 !ack_o;
  endsequence

  bus_ack_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      req |=> ack_pulse)
    else $error("ack not a single cycle after request");

  ack_cause_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      ack_o |-> $past(req))
    else $error("ack without a request");

  status_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (rd && hit_status) |=> (dat_o == {16'h0000, $past(status)}))
    else $error("status read back wrong");

  unmapped_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      (rd && !hit_status && !hit_mask) |=> (dat_o == 32'h0000_0000))
    else $error("unmapped read not zero");

  rdata_idle_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      !rd |=> (dat_o == 32'h0000_0000))
    else $error("read data outside a read cycle");

  rdata_upper_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
      dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");

endmodule

/* File: nim_irq_mask_test.sv */
`timescale 1ns/1ps
// ****************************************
// Bench for the interrupt enable mask
// ****************************************
module nim_irq_mask_test;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 cyc_i = 1'b0;
  logic                 stb_i = 1'b0;
  logic                 we_i  = 1'b0;
  logic [7:0]           adr_i = 8'h00;
  logic [3:0]           sel_i = 4'hf;
  logic [31:0]          dat_i = 32'h0;
  logic [31:0]          dat_o;
  logic                 ack_o;
  logic                 irq_o;
  nim_pkg::nim_events_s ev = '0;
  int                   mismatches = 0;
  int                   n_checks = 0;
  logic [31:0]          q;

  always #20 clk_i = ~clk_i;

  nim_irq_mask i_nim_irq_mask (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cyc_i    (cyc_i),
    .stb_i    (stb_i),
    .we_i     (we_i),
    .adr_i    (adr_i),
    .sel_i    (sel_i),
    .dat_i    (dat_i),
    .dat_o    (dat_o),
    .ack_o    (ack_o),
    .events_i (ev),
    .irq_o    (irq_o)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits on ack with a bound, so a dead slave cannot hang the run
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic pulse(input int b);
    @(posedge clk_i);
    ev <= nim_pkg::nim_events_s'(16'h1 << b);
    @(posedge clk_i);
    ev <= '0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, nim_pkg::MASK_OFS, 32'h0);
    chk("mask reset", {16'h0, nim_pkg::MASK_RESET}, q);
    wb(1'b0, nim_pkg::STATUS_OFS, 32'h0);
    chk("status reset", {16'h0, nim_pkg::STATUS_RESET}, q);
    // Software keeps the reserved top bit at zero
    wb(1'b1, nim_pkg::MASK_OFS, 32'h0000_7fff);
    wb(1'b0, nim_pkg::MASK_OFS, 32'h0);
    chk("mask readback", {16'h0, nim_pkg::IMPL_BITS}, q);
    // Only the low byte lane is written
    wb(1'b1, nim_pkg::MASK_OFS, 32'h0, 4'h1);
    wb(1'b0, nim_pkg::MASK_OFS, 32'h0);
    chk("mask low lane", {16'h0, nim_pkg::IMPL_BITS & 16'hff00}, q);
    wb(1'b0, 8'h3c, 32'h0);
    chk("unmapped read", 32'h0, q);
    // Reserved top event must never reach the output
    pulse(15);
    chk("irq reserved", 32'h0, {31'h0, irq_o});
    for (int b = 0; b < 15; b++) begin
      if (nim_pkg::IMPL_BITS[b]) begin
        wb(1'b1, nim_pkg::MASK_OFS, 32'h0);
        pulse(b);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        wb(1'b0, nim_pkg::STATUS_OFS, 32'h0);
        chk("status masked", 32'h1 << b, q);
        wb(1'b1, nim_pkg::STATUS_OFS, 32'h1 << b);
        wb(1'b1, nim_pkg::MASK_OFS, 32'h1 << b);
        pulse(b);
        chk("irq enabled", 32'h1, {31'h0, irq_o});
        wb(1'b1, nim_pkg::STATUS_OFS, 32'h1 << b);
        @(posedge clk_i);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        wb(1'b0, nim_pkg::MASK_OFS, 32'h0);
        chk("mask kept", 32'h1 << b, q);
      end
    end
    // Mid-run reset drops every register back to its reset value
    wb(1'b1, nim_pkg::MASK_OFS, 32'h0000_7fff);
    pulse(nim_pkg::TX_DONE_BIT);
    chk("irq before reset", 32'h1, {31'h0, irq_o});
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("irq after reset", 32'h0, {31'h0, irq_o});
    wb(1'b0, nim_pkg::MASK_OFS, 32'h0);
    chk("mask after reset", {16'h0, nim_pkg::MASK_RESET}, q);
    wb(1'b0, nim_pkg::STATUS_OFS, 32'h0);
    chk("status after reset", {16'h0, nim_pkg::STATUS_RESET}, q);
    finish_test();
  end

  // Generous bound: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end
endmodule

/* File: nim_pkg.sv */
package nim_pkg;

  // ********************************************************************
  // Bus geometry and register map
  // ********************************************************************
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned REG_W      = 16;
  localparam logic [7:0]  STATUS_OFS = 8'h00;
  localparam logic [7:0]  MASK_OFS   = 8'h04;

  // ********************************************************************
  // Reset values and implemented bits
  // ********************************************************************
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET   = 16'h0000;
  localparam logic [15:0] IMPL_BITS    = 16'h7f0f;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int BUS_RETRY_BIT   = 14;
  localparam int HB_LOST_BIT     = 13;
  localparam int FILTER_LOAD_BIT = 12;
  localparam int PER_PACKET_BIT  = 11;
  localparam int RX_PACKET_BIT   = 10;
  localparam int TX_DONE_BIT     = 9;
  localparam int TX_ERROR_BIT    = 8;
  localparam int CRC_TALLY_BIT   = 3;
  localparam int ALIGN_TALLY_BIT = 2;
  localparam int MISSED_PKT_BIT  = 1;
  localparam int RX_OVERRUN_BIT  = 0;

  // Event pulses, laid out like the status and mask registers
  typedef struct packed {
    logic       reserved_top;
    logic       bus_retry;
    logic       heartbeat_lost;
    logic       filter_load_done;
    logic       descriptor_irq_request;
    logic       rx_packet;
    logic       tx_done;
    logic       tx_error;
    logic [3:0] reserved_mid;
    logic       crc_tally;
    logic       align_err_tally;
    logic       missed_pkt_tally;
    logic       rx_fifo_overrun;
  } nim_events_s;

endpackage
